// File: rtl/eds_cfg.svh
// constants for the encoder direction and zero-set control logic
// assumes a 250 MHz core clock and the 25-bit position range
`ifndef EDS_CFG_SVH
`define EDS_CFG_SVH

`define EDS_CLK_PERIOD_NS 4
`define EDS_RESP_TIME_MS 10
// 10 ms at 4 ns: 2_500_000 cycles, exact so no rounding
`define EDS_RESP_CYCLES ((`EDS_RESP_TIME_MS * 1000000) / `EDS_CLK_PERIOD_NS)
`define EDS_POS_W 25
`define EDS_STATUS_COUNT 4
`define EDS_LIMIT_COUNT 2
`define EDS_SETPOINT_RESET 25'h000_0000
`define EDS_DIR_CCW_RESET 1'h0
`define EDS_PIN_DIR_RESET 1'h0
`define EDS_FUNC_W 3
`define EDS_FUNC_OFF 3'h0
`define EDS_FUNC_BATTERY 3'h1
`define EDS_FUNC_LIMIT_ONE 3'h2
`define EDS_FUNC_LIMIT_TWO 3'h3
`define EDS_FUNC_OVERSPEED 3'h4
`define EDS_FUNC_TEMP 3'h5

`endif

// File: rtl/eds_device.sv
// encoder end: direction resolve, zero-set alignment, status outputs
// assumes raw position from the sensor path on clk, cw counting up;
// reset stands for power-up
`timescale 1ns/100ps
`default_nettype none
`include "eds_cfg.svh"

// Function
// RULE_01: rising codes for either rotation sense
// RULE_02: programmed ccw wins, else pin decides
// RULE_03: direction pin sampled only at power-up
// RULE_04: unconfigured direction pin means clockwise
// RULE_05: direction pin settles within 10 ms
// RULE_06: direction change may shift reported position
// RULE_07: host straps direction, powers, then sets; the host here can raise zero-set on its strap-capture edge
// RULE_08: zero-set held 10 ms loads setpoint
// RULE_09: setpoint defaults zero, any in range
// RULE_10: no valid position during zero-set
// RULE_11: host sends no serial clock during set
// RULE_12: zero-set reacts within 10 ms
// RULE_13: four status outputs, first defaults battery
// RULE_14: two programmable limit-switch thresholds
// RULE_15: one load per pulse, valid after release
module eds_device
    import eds_pkg::*;
#(
    parameter int POS_W       = `EDS_POS_W,
    parameter int RESP_CYCLES = `EDS_RESP_CYCLES
)
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    eds_link_if.device                  link,
    input  wire logic                   cfg_we,
    input  wire logic                   cfg_dir_ccw,
    input  wire logic [POS_W-1:0]       cfg_setpoint,
    input  wire eds_func_t [3:0]        cfg_func,
    input  wire logic [1:0][POS_W-1:0]  cfg_limit,
    input  wire logic [POS_W-1:0]       raw_position,
    input  wire logic                   battery_low,
    input  wire logic                   overspeed,
    input  wire logic                   temp_alarm,
    output logic [POS_W-1:0]            position,
    output logic                        position_valid,
    output logic                        serial_clock,
    output logic                        dir_ccw,
    output logic                        dir_locked,
    output logic                        set_applied
);
    localparam int CNT_W = $clog2(RESP_CYCLES + 1);

    // programmed settings
    logic                  prog_ccw_reg;
    logic [POS_W-1:0]      setpoint_reg;
    eds_func_t [3:0]       func_reg;
    logic [1:0][POS_W-1:0] limit_reg;

    // pin synchronisers: first stage read only by second
    logic [2:0]            pin_s1_reg;
    logic [2:0]            pin_s2_reg;
    logic                  dir_pin;
    logic                  set_pin;
    logic                  clk_pin;

    logic [CNT_W-1:0]      dir_cnt_reg;
    logic                  dir_lock_reg;
    logic                  dir_level_reg;
    logic                  dir_ccw_w;

    eds_zs_state_t         zs_reg;
    eds_zs_state_t         zs_next;
    logic [CNT_W-1:0]      zs_cnt_reg;
    logic [CNT_W-1:0]      zs_cnt_next;
    logic                  zs_load;

    logic [POS_W-1:0]      offset_reg;
    logic [POS_W-1:0]      oriented;
    logic [POS_W-1:0]      position_reg;
    logic                  valid_reg;
    logic                  applied_reg;
    logic [3:0]            status_reg;
    logic [1:0]            limit_hit;

    function automatic logic [POS_W-1:0] orient(
        input logic [POS_W-1:0] raw,
        input logic             ccw
    );
        // mirrored count wraps within the measuring range
        orient = ccw ? (POS_W'(0) - raw) : raw;
    endfunction : orient

    function automatic logic pick(
        input eds_func_t  f,
        input logic [1:0] lim,
        input logic       bat,
        input logic       ovs,
        input logic       tmp
    );
        case (f)
            EDS_FUNC_BATTERY:   pick = bat;
            EDS_FUNC_LIMIT_ONE: pick = lim[0];
            EDS_FUNC_LIMIT_TWO: pick = lim[1];
            EDS_FUNC_OVERSPEED: pick = ovs;
            EDS_FUNC_TEMP:      pick = tmp;
            default:            pick = 1'b0;
        endcase
    endfunction : pick

    // RULE_09 setpoint resets to zero, full range accepted
    // RULE_13 first output battery, rest off
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            prog_ccw_reg <= `EDS_DIR_CCW_RESET;
            setpoint_reg <= POS_W'(`EDS_SETPOINT_RESET);
            func_reg     <= '{EDS_FUNC_OFF, EDS_FUNC_OFF, EDS_FUNC_OFF, EDS_FUNC_BATTERY};
            limit_reg    <= '0;
        end
        else if (cfg_we)
        begin
            prog_ccw_reg <= cfg_dir_ccw;
            setpoint_reg <= cfg_setpoint;
            func_reg     <= cfg_func;
            limit_reg    <= cfg_limit;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= {link.serial_clock_pin, link.zero_set_pin,
                           link.direction_select_pin};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign dir_pin = pin_s2_reg[0];
    assign set_pin = pin_s2_reg[1];
    assign clk_pin = pin_s2_reg[2];

    // RULE_03 sample once after power-up, then frozen
    // RULE_05 level taken at the end of the 10 ms window
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dir_cnt_reg   <= '0;
            dir_lock_reg  <= 1'b0;
            // RULE_04 default level is clockwise
            dir_level_reg <= `EDS_PIN_DIR_RESET;
        end
        else if (!dir_lock_reg)
        begin
            dir_cnt_reg <= dir_cnt_reg + CNT_W'(1);
            if (dir_cnt_reg == CNT_W'(RESP_CYCLES - 1))
            begin
                dir_lock_reg  <= 1'b1;
                dir_level_reg <= dir_pin;
            end
        end
    end

    // RULE_02 programmed ccw overrides the pin
    assign dir_ccw_w = prog_ccw_reg | dir_level_reg;

    // RULE_01 counting sense follows resolved direction
    assign oriented = orient(raw_position, dir_ccw_w);

    // RULE_08 held for the full window before loading
    // RULE_12 load lands 10 ms after the pin rose
    assign zs_load = (zs_reg == EDS_ZS_QUALIFY) && set_pin
                     && (zs_cnt_reg == CNT_W'(RESP_CYCLES - 1));

    always_comb
    begin
        zs_next     = zs_reg;
        zs_cnt_next = '0;
        case (zs_reg)
            EDS_ZS_IDLE:
            begin
                if (set_pin)
                    zs_next = EDS_ZS_QUALIFY;
            end
            EDS_ZS_QUALIFY:
            begin
                // a short pulse is dropped without effect
                if (!set_pin)
                    zs_next = EDS_ZS_IDLE;
                else if (zs_load)
                    zs_next = EDS_ZS_APPLIED;
                else
                    zs_cnt_next = zs_cnt_reg + CNT_W'(1);
            end
            // RULE_15 re-armed only after the pin drops
            EDS_ZS_APPLIED:
            begin
                if (!set_pin)
                    zs_next = EDS_ZS_IDLE;
            end
            default: zs_next = EDS_ZS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            zs_reg     <= EDS_ZS_IDLE;
            zs_cnt_reg <= '0;
        end
        else
        begin
            zs_reg     <= zs_next;
            zs_cnt_reg <= zs_cnt_next;
        end
    end

    // RULE_06 offset is volatile, so a direction change shifts output
    // RULE_15 single load per qualified pulse
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            offset_reg <= '0;
        else if (zs_load)
            offset_reg <= setpoint_reg - oriented;
    end

    // RULE_14 two limit thresholds
    assign limit_hit[0] = (position_reg >= limit_reg[0]);
    assign limit_hit[1] = (position_reg >= limit_reg[1]);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            position_reg <= '0;
            valid_reg    <= 1'b0;
            applied_reg  <= 1'b0;
            status_reg   <= '0;
        end
        else
        begin
            position_reg <= oriented + offset_reg;
            // RULE_10 invalid while the set pin is high
            valid_reg    <= dir_lock_reg && !set_pin;
            applied_reg  <= zs_load;
            // RULE_13 each output picks its programmed source
            for (int i = 0; i < 4; i++)
            begin
                status_reg[i] <= pick(func_reg[i], limit_hit, battery_low,
                                      overspeed, temp_alarm);
            end
        end
    end

    assign position                 = position_reg;
    assign position_valid           = valid_reg;
    // RULE_11 clocks during a set are not passed on
    assign serial_clock             = clk_pin && valid_reg;
    assign dir_ccw                  = dir_ccw_w;
    assign dir_locked               = dir_lock_reg;
    assign set_applied              = applied_reg;
    assign link.serial_data_valid   = valid_reg;
    assign link.status_output_one   = status_reg[0];
    assign link.status_output_two   = status_reg[1];
    assign link.status_output_three = status_reg[2];
    assign link.status_output_four  = status_reg[3];

endmodule : eds_device

`default_nettype wire

// File: rtl/eds_host.sv
// controller end: straps direction, pulses zero-set, gates serial clock
// assumes the device end on the far side of eds_link_if
`timescale 1ns/100ps
`default_nettype none
`include "eds_cfg.svh"

module eds_host
    import eds_pkg::*;
#(
    parameter int RESP_CYCLES = `EDS_RESP_CYCLES
)
(
    input  wire logic  clk,
    input  wire logic  reset,
    eds_link_if.host   link,
    input  wire logic  dir_strap_ccw,
    input  wire logic  set_request,
    input  wire logic  serial_clock_req,
    output logic       set_busy,
    output logic       serial_clock_allowed,
    output logic       serial_data_valid,
    output logic [3:0] status_outputs
);
    localparam int CNT_W = $clog2(RESP_CYCLES + 1);

    eds_hs_state_t    state_reg;
    eds_hs_state_t    state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             dir_reg;
    logic             strap_taken_reg;
    logic [4:0]       sync1_reg;
    logic [4:0]       sync2_reg;
    logic             pulse_done;
    logic             pulse_pin;

    // RULE_08 hold at least the qualify time
    assign pulse_done = (cnt_reg == CNT_W'(RESP_CYCLES));
    assign pulse_pin  = (state_reg == EDS_HS_PULSE);

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = '0;
        case (state_reg)
            EDS_HS_IDLE:
            begin
                if (set_request)
                    state_next = EDS_HS_PULSE;
            end
            EDS_HS_PULSE:
            begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (pulse_done)
                    state_next = EDS_HS_RELEASE;
            end
            // one idle cycle before a new pulse, the pin is low here
            EDS_HS_RELEASE: state_next = EDS_HS_IDLE;
            default:        state_next = EDS_HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= EDS_HS_IDLE;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // RULE_03 strap fixed once, before the device samples
    // RULE_07 strap taken on the first edge after reset; set_request is not held off, so zero-set can rise on that same edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dir_reg         <= `EDS_PIN_DIR_RESET;
            strap_taken_reg <= 1'b0;
        end
        else if (!strap_taken_reg)
        begin
            dir_reg         <= dir_strap_ccw;
            strap_taken_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {link.serial_data_valid, link.status_output_four,
                          link.status_output_three, link.status_output_two,
                          link.status_output_one};
            sync2_reg <= sync1_reg;
        end
    end

    assign link.direction_select_pin = dir_reg;
    assign link.zero_set_pin         = pulse_pin;
    // RULE_11 no serial clock during zero-set
    assign serial_clock_allowed      = (state_reg == EDS_HS_IDLE) && strap_taken_reg;
    assign link.serial_clock_pin     = serial_clock_req && serial_clock_allowed;
    assign set_busy                  = (state_reg != EDS_HS_IDLE) || !strap_taken_reg;
    assign serial_data_valid         = sync2_reg[4];
    assign status_outputs            = sync2_reg[3:0];

endmodule : eds_host

`default_nettype wire

// File: rtl/eds_link_if.sv
// pin-level link between the encoder control logic and its controller
// assumes both ends share nothing but these wires
`timescale 1ns/100ps
`default_nettype none

interface eds_link_if;
    logic direction_select_pin;
    logic zero_set_pin;
    logic serial_clock_pin;
    logic serial_data_valid;
    logic status_output_one;
    logic status_output_two;
    logic status_output_three;
    logic status_output_four;

    modport device (
        input  direction_select_pin,
        input  zero_set_pin,
        input  serial_clock_pin,
        output serial_data_valid,
        output status_output_one,
        output status_output_two,
        output status_output_three,
        output status_output_four
    );

    modport host (
        output direction_select_pin,
        output zero_set_pin,
        output serial_clock_pin,
        input  serial_data_valid,
        input  status_output_one,
        input  status_output_two,
        input  status_output_three,
        input  status_output_four
    );
endinterface : eds_link_if

`default_nettype wire

// File: rtl/eds_pkg.sv
// types shared by both ends of the encoder control link
// assumes eds_cfg.svh is on the include path
`include "eds_cfg.svh"

package eds_pkg;

    typedef enum logic [`EDS_FUNC_W-1:0] {
        EDS_FUNC_OFF       = `EDS_FUNC_OFF,
        EDS_FUNC_BATTERY   = `EDS_FUNC_BATTERY,
        EDS_FUNC_LIMIT_ONE = `EDS_FUNC_LIMIT_ONE,
        EDS_FUNC_LIMIT_TWO = `EDS_FUNC_LIMIT_TWO,
        EDS_FUNC_OVERSPEED = `EDS_FUNC_OVERSPEED,
        EDS_FUNC_TEMP      = `EDS_FUNC_TEMP
    } eds_func_t;

    // gray along idle -> qualify -> applied
    typedef enum logic [1:0] {
        EDS_ZS_IDLE    = 2'h0,
        EDS_ZS_QUALIFY = 2'h1,
        EDS_ZS_APPLIED = 2'h3
    } eds_zs_state_t;

    // gray along idle -> pulse -> release
    typedef enum logic [1:0] {
        EDS_HS_IDLE    = 2'h0,
        EDS_HS_PULSE   = 2'h1,
        EDS_HS_RELEASE = 2'h3
    } eds_hs_state_t;

endpackage : eds_pkg

// File: verif/eds_monitor.sv
// link checker: strap, zero-set pulse, valid and serial clock timing
// assumes bench clk and reset, RESP_CYCLES equal to both ends
`timescale 1ns/100ps
`default_nettype none

module eds_monitor
#(
    parameter int RESP_CYCLES = 16
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic direction_select_pin,
    input wire logic zero_set_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_data_valid,
    input wire logic status_output_one,
    input wire logic status_output_two,
    input wire logic status_output_three,
    input wire logic status_output_four
);
    // counters instead of long repetitions, which the tools unroll
    logic [15:0] up_reg;
    logic [15:0] hi_reg;
    logic        seen_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            up_reg   <= 16'h0000;
            hi_reg   <= 16'h0000;
            seen_reg <= 1'b0;
        end
        else
        begin
            up_reg   <= (&up_reg) ? up_reg : up_reg + 16'h0001;
            hi_reg   <= zero_set_pin ? hi_reg + 16'h0001 : 16'h0000;
            seen_reg <= seen_reg | serial_data_valid;
        end
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_wait_for_lock: assert property ( // lock delay
        up_reg <= RESP_CYCLES |-> !serial_data_valid)
        else $error("position valid before direction lock");
    chk_valid_after_lock: assert property ( // lock bound
        (!zero_set_pin [*4]) ##0 (up_reg == RESP_CYCLES + 3) |-> serial_data_valid)
        else $error("position not valid after direction lock");
    chk_set_blocks_valid: assert property ( // no valid data
        zero_set_pin [*4] |-> !serial_data_valid)
        else $error("position valid during set pulse");
    chk_valid_after_set: assert property ( // valid returns
        $fell(zero_set_pin) && seen_reg |-> ##[1:4] serial_data_valid)
        else $error("position valid not restored after set pulse");
    chk_no_clock_in_set: assert property ( // clock quiet
        zero_set_pin |-> !serial_clock_pin)
        else $error("serial clock during set pulse");
    chk_pulse_length: assert property ( // full hold
        $fell(zero_set_pin) |-> hi_reg == RESP_CYCLES + 1)
        else $error("set pulse length wrong");
    chk_no_early_set: assert property ( // strap first
        up_reg < 2 |-> !zero_set_pin)
        else $error("set pulse before strap capture");
    chk_strap_frozen: assert property ( // strap fixed
        up_reg >= 2 |-> $stable(direction_select_pin))
        else $error("direction strap moved after power-up");
endmodule : eds_monitor

`default_nettype wire

// File: verif/encoder_direction_and_zero_set_tb_top.sv
// bench joining both ends of the encoder control link
// assumes RESP_CYCLES shortened to 16, checker beside the link wires
`timescale 1ns/100ps
`default_nettype none
`include "eds_cfg.svh"

module encoder_direction_and_zero_set_tb_top
    import eds_pkg::*;
;
    localparam int RESP = 16;

    logic                       clk;
    logic                       reset;
    logic                       cfg_we;
    logic                       cfg_dir_ccw;
    logic [`EDS_POS_W-1:0]      cfg_setpoint;
    eds_func_t [3:0]            cfg_func;
    logic [1:0][`EDS_POS_W-1:0] cfg_limit;
    logic [`EDS_POS_W-1:0]      raw_position;
    logic                       battery_low;
    logic                       overspeed;
    logic                       temp_alarm;
    logic [`EDS_POS_W-1:0]      position;
    logic                       position_valid;
    logic                       serial_clock;
    logic                       dir_ccw;
    logic                       dir_locked;
    logic                       set_applied;
    logic                       dir_strap_ccw;
    logic                       set_request;
    logic                       serial_clock_req;
    logic                       set_busy;
    logic                       serial_clock_allowed;
    logic                       host_valid;
    logic [3:0]                 status_outputs;
    int                         bad_count;
    int                         n_checks;
    int                         applied_count;

    eds_link_if i_eds_link_if ();

    eds_device #(.RESP_CYCLES(RESP)) i_eds_device (
        .clk(clk), .reset(reset), .link(i_eds_link_if.device), .cfg_we(cfg_we),
        .cfg_dir_ccw(cfg_dir_ccw), .cfg_setpoint(cfg_setpoint), .cfg_func(cfg_func),
        .cfg_limit(cfg_limit), .raw_position(raw_position), .battery_low(battery_low),
        .overspeed(overspeed), .temp_alarm(temp_alarm), .position(position),
        .position_valid(position_valid), .serial_clock(serial_clock),
        .dir_ccw(dir_ccw), .dir_locked(dir_locked), .set_applied(set_applied));

    eds_host #(.RESP_CYCLES(RESP)) i_eds_host (
        .clk(clk), .reset(reset), .link(i_eds_link_if.host),
        .dir_strap_ccw(dir_strap_ccw), .set_request(set_request),
        .serial_clock_req(serial_clock_req), .set_busy(set_busy),
        .serial_clock_allowed(serial_clock_allowed), .serial_data_valid(host_valid),
        .status_outputs(status_outputs));

    eds_monitor #(.RESP_CYCLES(RESP)) i_eds_monitor (
        .clk(clk), .reset(reset),
        .direction_select_pin(i_eds_link_if.direction_select_pin),
        .zero_set_pin(i_eds_link_if.zero_set_pin),
        .serial_clock_pin(i_eds_link_if.serial_clock_pin),
        .serial_data_valid(i_eds_link_if.serial_data_valid),
        .status_output_one(i_eds_link_if.status_output_one),
        .status_output_two(i_eds_link_if.status_output_two),
        .status_output_three(i_eds_link_if.status_output_three),
        .status_output_four(i_eds_link_if.status_output_four));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // set_applied is a one-cycle pulse, so count it off the falling edge
    always @(negedge clk)
    begin
        if (set_applied === 1'b1)
            applied_count <= applied_count + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // reset stands for a power cycle; strap set before release
    task automatic power_up(input logic strap);
        @(posedge clk);
        reset         <= 1'b1;
        dir_strap_ccw <= strap;
        step(7);
        @(posedge clk);
        reset <= 1'b0;
        step(RESP + 6);
        check(dir_locked, 1'b1, "direction lock"); // settled
    endtask : power_up

    task automatic load_cfg(input logic ccw, input logic [24:0] sp, input eds_func_t [3:0] f,
                            input logic [24:0] lim);
        @(posedge clk);
        cfg_we       <= 1'b1;
        cfg_dir_ccw  <= ccw;
        cfg_setpoint <= sp;
        cfg_func     <= f;
        cfg_limit[0] <= lim;
        @(posedge clk);
        cfg_we <= 1'b0;
        step(6);
    endtask : load_cfg

    task automatic do_set(input logic [24:0] exp);
        int i;
        applied_count = 0;
        @(posedge clk);
        set_request <= 1'b1;
        @(posedge clk);
        set_request <= 1'b0;
        step(RESP / 2);
        check(set_busy, 1'b1, "busy in pulse"); // held
        check(host_valid, 1'b0, "valid in pulse"); // no data
        check(position_valid, 1'b0, "device valid in pulse"); // no data
        check(serial_clock, 1'b0, "clock in pulse"); // gated
        check(serial_clock_allowed, 1'b0, "clock allowed"); // gated
        for (i = 0; i < 100 && set_busy === 1'b1; i++)
            step(1);
        step(8);
        check(position, exp, "position after set"); // aligned
        check(applied_count, 1, "loads per pulse"); // single load
        check(host_valid, 1'b1, "valid after set"); // restored
        check(position_valid, 1'b1, "device valid after set"); // restored
        check(serial_clock, 1'b1, "clock after set"); // restored
    endtask : do_set

    task automatic test_defaults();
        power_up(1'b0);
        check(dir_ccw, 1'b0, "default direction"); // cw
        check(status_outputs, 4'h1, "default status"); // battery only
        do_set(25'h000_0000); // zero default
        $display("done defaults");
    endtask : test_defaults

    task automatic test_zero_set();
        load_cfg(1'b1, 25'h123_4567, cfg_func, 25'h000_0000);
        do_set(25'h123_4567); // reacts
        @(posedge clk);
        raw_position <= raw_position + 25'h000_0003;
        step(4);
        check(position, 25'h123_4564, "ccw after set"); // setpoint kept
        $display("done zero set");
    endtask : test_zero_set

    task automatic test_direction();
        int s;
        for (s = 0; s < 2; s++)
        begin
            power_up(s[0]);
            @(posedge clk);
            raw_position  <= 25'h000_0005;
            dir_strap_ccw <= ~s[0];
            load_cfg(1'b0, 25'h000_0000, cfg_func, 25'h000_0000);
            check(dir_ccw, s[0], "pin decides"); // cw programmed
            check(dir_ccw, s[0], "strap after lock"); // ignored
            check(i_eds_link_if.direction_select_pin, s[0], "strap pin frozen"); // fixed
            check(position, s[0] ? 25'h1ff_fffb : 25'h000_0005, "oriented");
            load_cfg(1'b1, 25'h000_0000, cfg_func, 25'h000_0000);
            check(dir_ccw, 1'b1, "ccw wins"); // ccw programmed
            check(position, 25'h1ff_fffb, "ccw position"); // sense
        end
        $display("done direction");
    endtask : test_direction

    task automatic test_status();
        int p;
        int c;
        logic [5:0] e;
        for (p = 0; p < 2; p++)
        begin
            @(posedge clk);
            overspeed  <= ~p[0];
            temp_alarm <= p[0];
            e = p[0] ? 6'h22 : 6'h16;
            for (c = 0; c < 6; c++)
            begin
                load_cfg(1'b0, 25'h000_0000, '{4{eds_func_t'(c)}},
                         p[0] ? 25'h1ff_ffff : 25'h000_0000);
                check(status_outputs, {4{e[c]}}, "status function");
            end
        end
        $display("done status");
    endtask : test_status

    initial
    begin
        reset            = 1'b1;
        cfg_we           = 1'b0;
        cfg_dir_ccw      = 1'b0;
        cfg_setpoint     = 25'h000_0000;
        cfg_func         = '{EDS_FUNC_OFF, EDS_FUNC_OFF, EDS_FUNC_OFF, EDS_FUNC_BATTERY};
        cfg_limit        = {25'h1ff_ffff, 25'h000_0000};
        raw_position     = 25'h000_0064;
        battery_low      = 1'b1;
        overspeed        = 1'b0;
        temp_alarm       = 1'b0;
        dir_strap_ccw    = 1'b0;
        set_request      = 1'b0;
        serial_clock_req = 1'b1;
        bad_count        = 0;
        n_checks         = 0;
        applied_count    = 0;
        test_defaults();
        test_zero_set();
        test_direction();
        test_status();
        summarize();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end
endmodule : encoder_direction_and_zero_set_tb_top

`default_nettype wire
